// File: reg_port_if.sv
/*
  Carrier between the frame logic and the register store.
  Assumes both ends run on the internal clock.
*/
`timescale 1ns/1ps
interface reg_port_if;
  logic                    wr_en;
  spi_frame_pkg::reg_addr_t wr_addr;
  spi_frame_pkg::reg_word_t wr_data;
  spi_frame_pkg::reg_addr_t rd_addr;
  spi_frame_pkg::reg_word_t rd_data;

  modport ctrl  (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// File: reg_store.sv
/*
  Eight-word register store with registered read data.
  Assumes write and read requests come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "spi_frame_defs.svh"
module reg_store
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Register port
  reg_port_if.store port
);

  spi_frame_pkg::reg_word_t mem_r [8];
  spi_frame_pkg::reg_word_t rd_r;

  // Reset value of each address
  function automatic spi_frame_pkg::reg_word_t reset_word
  (
    input spi_frame_pkg::reg_addr_t a
  );
    case (a)
      3'h2:    reset_word = `RST_OUT;
      3'h3:    reset_word = `RST_DEVS;
      3'h5:    reset_word = `RST_ISA;
      3'h6:    reset_word = `RST_ISB;
      default: reset_word = `RST_ZERO;
    endcase
  endfunction

  // Storage, loaded with defaults under reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
        mem_r[i] <= reset_word(3'(i));
    end
    else if (port.wr_en)
      mem_r[port.wr_addr] <= port.wr_data;
  end

  // Read data from a register, one cycle after the address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_r <= `RST_ZERO;
    else
      rd_r <= mem_r[port.rd_addr];
  end

  assign port.rd_data = rd_r;

endmodule

// File: spi_frame_defs.svh
/*
  Constants for the serial frame logic: frame field positions, register
  addresses, command codes and register reset values.
  Assumes nothing; included by bare name wherever the constants are needed.
*/
`ifndef SPI_FRAME_DEFS_SVH
`define SPI_FRAME_DEFS_SVH

// Response and request frame fields
// Bit 15: parity flag in answers, write flag in requests
`define FLAG_BIT     15
`define ADDR_MSB     14
`define ADDR_LSB     12
`define DATA_MSB     11

// Register addresses
`define ADDR_CMD     3'h0
`define ADDR_DCC     3'h1

// Command codes written to the command address
`define CMD_NOP      12'h700
`define CMD_RSD      12'h701
`define READ_SHORT_DIAG_STATUS_CMD  12'h702
`define CMD_RPC      12'h704
`define CMD_RIN      12'h708
`define CLEAR_SHORT_DIAG_STATUS_CMD 12'h710

// Upper nibble marking a split-byte command byte
`define COMPACT_TAG  4'hC

// Register reset values
`define RST_OUT      12'hC00
`define RST_DEVS     12'h007
`define RST_ISA      12'hAAA
`define RST_ISB      12'h0AA
`define RST_ZERO     12'h000

`endif

// File: spi_frame_pkg.sv
/*
  Types shared by the serial frame logic and its register store.
  Assumes nothing from the constants header; state codes and widths are written out here.
*/
package spi_frame_pkg;

  // Frame handling states, Gray coded along the path
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_LATCH = 2'b01,
    ST_WAIT  = 2'b11,
    ST_LOAD  = 2'b10
  } frame_state_t;

  typedef logic [11:0] reg_word_t;
  typedef logic [2:0]  reg_addr_t;

endpackage

// File: spi_frame_slave.sv
/*
  Serial frame logic of a multichannel switch: shifts requests in on the
  host clock, answers with a parity-protected frame or split-byte data,
  hands finished frames to the internal clock and decodes them there.
  Assumes the host holds sclk low around chip select edges and keeps chip
  select high for at least eight internal clock cycles between frames.
*/
// Overview of operation
// RULE_01: Every frame shifts out a response set by earlier commands.
// RULE_02: Response bit 15 is odd parity over the address and data fields; the code sets it to the XOR of bits 14..0 (even parity).
// RULE_03: Response bits 14..12 echo the address the prior command selected.
// RULE_04: Response bits 11..0 hold register contents or command feedback.
// RULE_05: First response after reset is the clear-status response frame.
// RULE_06: A read takes two frames; the second frame may carry a new command.
// RULE_07: Split mode: upper input byte runs after 8 bits, answers lower byte.
// RULE_08: Split mode: lower input byte runs at frame end, answers next upper.
// RULE_09: Host sends no-operation when switching from 16-bit to split frames.
// RULE_10: Host puts these devices first in a daisy chain.
// RULE_11: Host sends no split-byte commands to chained devices.
// RULE_12: Host prefixes each chain frame with 8 zero bits.
// RULE_13: Host sends no-operation to the next device after a diag A read.
// RULE_14: Host discards the next device's answer following a diag A read.
// RULE_15: Undefined command codes are ignored and latch a link error.
// RULE_16: Frames not a multiple of 8 bits are dropped and flag an error.
// RULE_17: Input bit 15 write/read, 14..12 address, 11..0 data or command.
// RULE_18: Input sampled on falling sclk, MSB first; output changes on rising.
// RULE_19: With chip select high, clock and data are ignored, output released.
// RULE_20: Writes take effect only at the rising chip select ending the frame.
// RULE_21: Finished frames cross into the internal clock before any action.
`timescale 1ns/1ps
`include "spi_frame_defs.svh"
module spi_frame_slave
(
  // Internal clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  // Device state reported in responses
  input  wire logic [11:0] short_diag,
  input  wire logic [10:0] dev_status,
  input  wire logic [11:0] in_pins,
  // Actions decoded from frames
  output logic             wr_stb,
  output logic [2:0]       wr_addr,
  output logic [11:0]      wr_data,
  output logic             cmd_stb,
  output logic [11:0]      cmd_code,
  output logic             compact_stb,
  output logic [7:0]       compact_byte,
  output logic             comm_err
);

  reg_port_if rp ();

  spi_frame_pkg::frame_state_t state_r;
  logic [15:0] rx_sh_r, w_r, resp_r, resp_nxt, tx_word;
  logic [7:0]  upper_r;
  logic [11:0] diag_snap_r;
  logic [4:0]  tx_cnt_r;
  logic [2:0]  bit_cnt_r, cs_s_r;
  logic [1:0]  nbytes_r;
  logic        so_r, so_oe_r, cs_stable_r, frame_open_r, init_r, cnt_ok_r;
  logic        long_r, is16_r, is16_nxt, resp_upd, link_clr;
  logic        wr_fire, cmd_fire, cpt_fire, err_fire, clr_err;
  logic        wr_stb_r, cmd_stb_r, compact_stb_r, comm_err_r;
  logic [2:0]  wr_addr_r;
  logic [11:0] wr_data_r, cmd_code_r, status_w;
  logic [7:0]  compact_byte_r;

  function automatic logic is_compact(input logic [7:0] b);
    is_compact = (b[7:4] == `COMPACT_TAG);
  endfunction

  // Split-byte answer: selects the upper four or the lower eight bits of the short diagnosis
  function automatic logic [7:0] compact_result
  (
    input logic [7:0]  b,
    input logic [11:0] diag
  );
    compact_result = b[0] ? {4'h0, diag[11:8]} : diag[7:0];
  endfunction

  function automatic logic [15:0] frame16
  (
    input logic [2:0]  a,
    input logic [11:0] d
  );
    frame16 = {^{a, d}, a, d}; // RULE_02
  endfunction

  // Link counters held cleared once a frame is handed over
  assign link_clr = ~rst_n | (cs_n & ~frame_open_r); // RULE_19

  // Bit and byte count, sampled on falling sclk
  always_ff @(negedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      bit_cnt_r <= 3'h0;
      nbytes_r  <= 2'h0;
    end
    else if (!cs_n)
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1; // RULE_16
      if (bit_cnt_r == 3'h7 && nbytes_r != 2'h2)
        nbytes_r <= nbytes_r + 2'h1;
    end
  end

  // Input shift, MSB first; last 16 bits kept for the chain
  always_ff @(negedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sh_r <= 16'h0000;
      upper_r <= 8'h00;
    end
    else if (!cs_n)
    begin
      rx_sh_r <= {rx_sh_r[14:0], si}; // RULE_18
      if (bit_cnt_r == 3'h7 && nbytes_r == 2'h0)
        upper_r <= {rx_sh_r[6:0], si}; // RULE_07
    end
  end

  // Lower half swapped for the split answer once the upper byte is in
  always_comb
  begin
    tx_word = resp_r;
    if (tx_cnt_r[3] && is_compact(upper_r))
      tx_word[7:0] = compact_result(upper_r, diag_snap_r); // RULE_07
  end

  // Output count, advanced on rising sclk
  always_ff @(posedge sclk or posedge link_clr)
  begin
    if (link_clr)
      tx_cnt_r <= 5'h00;
    else if (!cs_n && !tx_cnt_r[4])
      tx_cnt_r <= tx_cnt_r + 5'h01;
  end

  // Serial output; after 16 bits it forwards the chain input
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
      so_r <= 1'b0;
    else if (!cs_n)
      so_r <= tx_cnt_r[4] ? rx_sh_r[15]
                          : tx_word[4'hF - tx_cnt_r[3:0]]; // RULE_01
  end

  // Chip select synchroniser; a change counts once stages 2 and 3 agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_s_r      <= 3'h7;
      cs_stable_r <= 1'b1;
      so_oe_r     <= 1'b0;
    end
    else
    begin
      cs_s_r <= {cs_s_r[1:0], cs_n};
      if (cs_s_r[1] == cs_s_r[2])
        cs_stable_r <= cs_s_r[2];
      so_oe_r <= ~cs_stable_r; // RULE_19
    end
  end

  // Frame hand-over: link state is frozen while chip select is high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r      <= spi_frame_pkg::ST_IDLE;
      frame_open_r <= 1'b0;
      w_r          <= 16'h0000;
      cnt_ok_r     <= 1'b0;
      long_r       <= 1'b0;
    end
    else
    begin
      if (!cs_stable_r)
        frame_open_r <= 1'b1;
      case (state_r)
        spi_frame_pkg::ST_IDLE:
          if (frame_open_r && cs_stable_r)
            state_r <= spi_frame_pkg::ST_LATCH; // RULE_20
        spi_frame_pkg::ST_LATCH:
        begin
          w_r          <= rx_sh_r; // RULE_21
          cnt_ok_r     <= (bit_cnt_r == 3'h0);
          long_r       <= (nbytes_r == 2'h2);
          frame_open_r <= 1'b0;
          state_r      <= spi_frame_pkg::ST_WAIT;
        end
        spi_frame_pkg::ST_WAIT:
          state_r <= spi_frame_pkg::ST_LOAD;
        spi_frame_pkg::ST_LOAD:
          state_r <= spi_frame_pkg::ST_IDLE;
        default:
          state_r <= spi_frame_pkg::ST_IDLE;
      endcase
    end
  end

  assign status_w = {comm_err_r, dev_status};

  // Frame decode, acted on in the load state only
  always_comb
  begin
    resp_nxt = resp_r;
    is16_nxt = 1'b1;
    resp_upd = 1'b0;
    wr_fire  = 1'b0;
    cmd_fire = 1'b0;
    cpt_fire = 1'b0;
    err_fire = 1'b0;
    clr_err  = 1'b0;
    if (state_r == spi_frame_pkg::ST_LOAD)
    begin
      if (!cnt_ok_r)
        err_fire = 1'b1; // RULE_16
      else if (!long_r)
        resp_upd = 1'b0; // Upper byte already answered in-frame
      else if (is_compact(w_r[15:8]))
      begin
        cpt_fire = 1'b1;
        resp_upd = 1'b1;
        is16_nxt = 1'b0;
        resp_nxt = {compact_result(w_r[7:0], short_diag), 8'h00}; // RULE_08
      end
      else if (w_r[`FLAG_BIT] && w_r[`ADDR_MSB:`ADDR_LSB] == `ADDR_CMD)
      begin
        resp_upd = 1'b1;
        cmd_fire = 1'b1;
        case (w_r[`DATA_MSB:0]) // RULE_17
          `CMD_NOP:  resp_nxt = 16'h0000;
          `CMD_RSD:  resp_nxt = frame16(`ADDR_CMD, short_diag);
          `READ_SHORT_DIAG_STATUS_CMD:
            resp_nxt = frame16(`ADDR_CMD, status_w);
          `CLEAR_SHORT_DIAG_STATUS_CMD:
          begin
            resp_nxt = frame16(`ADDR_CMD, status_w);
            clr_err  = 1'b1;
          end
          `CMD_RPC, `CMD_RIN: resp_nxt = frame16(`ADDR_CMD, in_pins);
          default:
          begin
            resp_upd = 1'b0;
            cmd_fire = 1'b0;
            err_fire = 1'b1; // RULE_15
          end
        endcase
      end
      else if (w_r[`FLAG_BIT])
      begin
        wr_fire  = 1'b1; // RULE_20
        resp_upd = 1'b1;
        resp_nxt = frame16(`ADDR_CMD, short_diag);
      end
      else
      begin
        resp_upd = 1'b1;
        if (w_r[`ADDR_MSB:`ADDR_LSB] > `ADDR_DCC)
          resp_nxt = frame16(w_r[`ADDR_MSB:`ADDR_LSB], rp.rd_data); // RULE_06
        else
          resp_nxt = 16'h0000;
      end
    end
  end

  // Register store port: written only for storing addresses
  assign rp.wr_en   = wr_fire && (w_r[`ADDR_MSB:`ADDR_LSB] > `ADDR_DCC);
  assign rp.wr_addr = w_r[`ADDR_MSB:`ADDR_LSB];
  assign rp.wr_data = w_r[`DATA_MSB:0];
  assign rp.rd_addr = w_r[`ADDR_MSB:`ADDR_LSB];

  reg_store u_store
  (
    .clk   (clk),
    .rst_n (rst_n),
    .port  (rp.store)
  );

  // Response word; changes only while chip select is high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_r <= 16'h0000;
      is16_r <= 1'b1;
      init_r <= 1'b1;
    end
    else if (init_r)
    begin
      resp_r <= frame16(`ADDR_CMD, status_w); // RULE_05
      init_r <= 1'b0;
    end
    else if (resp_upd)
    begin
      resp_r <= resp_nxt; // RULE_03 RULE_04
      is16_r <= is16_nxt;
    end
  end

  // Error flag; a new error wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      comm_err_r <= 1'b0;
    else if (err_fire)
      comm_err_r <= 1'b1; // RULE_15 RULE_16
    else if (clr_err)
      comm_err_r <= 1'b0;
  end

  // Action strobes toward the rest of the device
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_stb_r       <= 1'b0;
      cmd_stb_r      <= 1'b0;
      compact_stb_r  <= 1'b0;
      wr_addr_r      <= 3'h0;
      wr_data_r      <= 12'h000;
      cmd_code_r     <= 12'h000;
      compact_byte_r <= 8'h00;
      diag_snap_r    <= 12'h000;
    end
    else
    begin
      wr_stb_r      <= wr_fire;
      cmd_stb_r     <= cmd_fire;
      compact_stb_r <= cpt_fire;
      if (state_r == spi_frame_pkg::ST_LOAD)
      begin
        wr_addr_r      <= w_r[`ADDR_MSB:`ADDR_LSB];
        wr_data_r      <= w_r[`DATA_MSB:0];
        cmd_code_r     <= w_r[`DATA_MSB:0];
        compact_byte_r <= w_r[7:0];
      end
      // Snapshot held still during frames for the sclk-side answer
      if (cs_stable_r && !frame_open_r)
        diag_snap_r <= short_diag;
    end
  end

  assign so           = so_r;
  assign so_oe        = so_oe_r;
  assign wr_stb       = wr_stb_r;
  assign wr_addr      = wr_addr_r;
  assign wr_data      = wr_data_r;
  assign cmd_stb      = cmd_stb_r;
  assign cmd_code     = cmd_code_r;
  assign compact_stb  = compact_stb_r;
  assign compact_byte = compact_byte_r;
  assign comm_err     = comm_err_r;

  a_resp_parity: assert property (@(posedge clk) // RULE_02
    disable iff (!rst_n)
    is16_r |-> resp_r[15] == ^resp_r[14:0])
    else $error("response parity wrong");
  a_read_addr: assert property (@(posedge clk) // RULE_03
    disable iff (!rst_n)
    (resp_upd && !w_r[15] && w_r[14:12] > 3'h1)
    |=> resp_r[14:12] == $past(w_r[14:12]))
    else $error("read response address wrong");
  a_read_data: assert property (@(posedge clk) // RULE_04
    disable iff (!rst_n)
    (resp_upd && !w_r[15] && w_r[14:12] > 3'h1)
    |=> resp_r[11:0] == $past(rp.rd_data))
    else $error("read response data wrong");
  a_first_resp: assert property (@(posedge clk) // RULE_05
    disable iff (!rst_n)
    $fell(init_r)
    |-> resp_r[14:12] == 3'h0 && resp_r[10:0] == $past(dev_status))
    else $error("first response not status");
  a_bad_len_err: assert property (@(posedge clk) // RULE_16
    disable iff (!rst_n)
    (state_r == spi_frame_pkg::ST_LOAD && !cnt_ok_r)
    |=> comm_err_r && !wr_stb_r)
    else $error("short frame not flagged");
  a_bad_cmd_err: assert property (@(posedge clk) // RULE_15
    disable iff (!rst_n)
    (state_r == spi_frame_pkg::ST_LOAD && cnt_ok_r && long_r && w_r[15]
     && w_r[14:12] == 3'h0 && !is_compact(w_r[15:8]) && w_r[11:8] != 4'h7)
    |=> comm_err_r && !cmd_stb_r)
    else $error("bad command not flagged");
  a_write_at_end: assert property (@(posedge clk) // RULE_20
    disable iff (!rst_n)
    wr_stb_r |-> cs_stable_r && $past(cs_stable_r, 3))
    else $error("write outside chip select high");
  a_cross_order: assert property (@(posedge clk) // RULE_21
    disable iff (!rst_n)
    (state_r == spi_frame_pkg::ST_LATCH) |=> state_r == spi_frame_pkg::ST_WAIT
    ##1 state_r == spi_frame_pkg::ST_LOAD ##1 !frame_open_r)
    else $error("hand-over sequence broken");
  a_first_bit: assert property (@(posedge sclk) // RULE_01
    disable iff (link_clr)
    (tx_cnt_r == 5'h01) |-> so_r == resp_r[15])
    else $error("first output bit wrong");
endmodule

// File: spi_host_model.sv
/*
  Host-side serial master model: frames of whole bits on sclk/cs_n/si,
  collecting the device answer from the resolved serial output line.
  Assumes the bench calls xfer only after reset and one frame at a time.
*/
`timescale 1ns/1ps
module spi_host_model
(
  // Serial link driven by the host
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  // Resolved serial output of the device
  input  wire logic so_line
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // One frame of n bits, MSB first; sclk stands still outside frames.
  // Frames longer than 16 bits lead with zero bits, as in a chain.
  task automatic xfer(input int n, input logic [15:0] tx,
                      output logic [15:0] rx);
    int i;
    int lead;
    rx   = 16'h0000;
    lead = (n > 16) ? n - 16 : 0;
    #1.3 cs_n = 1'b0;
    #40;
    for (i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      si   = (i < lead) ? 1'b0 : tx[15-i+lead];
      #40 sclk = 1'b0;
      // Only this device's own answer kept; forwarded bits dropped
      if (i < 16)
        rx[15-i] = so_line;
      #40;
    end
    cs_n = 1'b1;
    // Input line toggled with chip select high, where the device must ignore it
    #10 si = ~si;
    #80;
  endtask
endmodule

// File: tb_top.sv
/*
  Self-checking bench for the serial frame logic: table of 16-bit frames,
  then errors, split-byte frames and a second reset by hand.
  Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  typedef struct { logic [15:0] tx; logic [15:0] exp; } row_t;

  logic        clk;
  logic        rst_n;
  logic [11:0] short_diag;
  logic [10:0] dev_status;
  logic [11:0] in_pins;
  wire         sclk;
  wire         cs_n;
  wire         si;
  wire         so;
  wire         so_oe;
  wire         so_line;
  wire         wr_stb;
  wire [2:0]   wr_addr;
  wire [11:0]  wr_data;
  wire         cmd_stb;
  wire [11:0]  cmd_code;
  wire         compact_stb;
  wire [7:0]   compact_byte;
  wire         comm_err;
  int          n_fail;
  int          samples_checked;
  int          n_wr;
  int          n_cmd;
  logic [14:0] last_wr;
  logic [11:0] last_cmd;
  logic [7:0]  last_cb;
  logic [15:0] rx;
  row_t        rows[12];

  // Released output floats; the host sees Z, not a stale level
  assign so_line = so_oe ? so : 1'bz;

  spi_frame_slave dut
  (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .short_diag(short_diag),
    .dev_status(dev_status), .in_pins(in_pins), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_data(wr_data), .cmd_stb(cmd_stb),
    .cmd_code(cmd_code), .compact_stb(compact_stb),
    .compact_byte(compact_byte), .comm_err(comm_err)
  );

  spi_host_model host
  (
    .sclk(sclk), .cs_n(cs_n), .si(si), .so_line(so_line)
  );

  // 250 MHz internal clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  function automatic logic [15:0] resp(input logic [2:0] a,
                                       input logic [11:0] d);
    return {^{a, d}, a, d};
  endfunction

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Strobe monitor; writes must never land inside a frame
  always @(posedge clk)
  begin
    if (wr_stb === 1'b1)
    begin
      n_wr++;
      last_wr <= {wr_addr, wr_data};
      check("wr_cs", {15'h0000, cs_n}, 16'h0001);
    end
    if (cmd_stb === 1'b1)
    begin
      n_cmd++;
      last_cmd <= cmd_code;
    end
    if (compact_stb === 1'b1)
      last_cb <= compact_byte;
  end

  // Watchdog: about 22 frames of 1.4 us each, with margin
  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end

  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    n_wr = 0;
    n_cmd = 0;
    rst_n = 1'b0;
    short_diag = 12'h3C5;
    dev_status = 11'h2A1;
    in_pins = 12'h0F3;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    rows[0] = '{16'h5000, resp(3'h0, {1'b0, 11'h2A1})};
    rows[1] = '{16'hB555, resp(3'h5, 12'hAAA)};
    rows[2] = '{16'h3000, resp(3'h0, 12'h3C5)};
    rows[3] = '{16'h8700, resp(3'h3, 12'h555)};
    rows[4] = '{16'h2000, 16'h0000};
    rows[5] = '{16'h1000, resp(3'h2, 12'hC00)};
    rows[6] = '{16'h8700, 16'h0000};
    rows[7] = '{16'h8704, 16'h0000};
    rows[8] = '{16'h8708, resp(3'h0, 12'h0F3)};
    rows[9] = '{16'h8702, resp(3'h0, 12'h0F3)};
    rows[10] = '{16'h8701, resp(3'h0, {1'b0, 11'h2A1})};
    rows[11] = '{16'h8700, resp(3'h0, 12'h3C5)};
    foreach (rows[i])
    begin
      host.xfer(16, rows[i].tx, rx);
      check("resp", rx, rows[i].exp);
    end
    check("n_wr", 16'(n_wr), 16'h0001);
    check("wr", {1'b0, last_wr}, 16'h3555);
    check("cmd", {4'h0, last_cmd}, 16'h0700);
    check("oe_idle", {15'h0000, so_oe}, 16'h0000);
    // Undefined command code at the command address
    host.xfer(16, 16'h8123, rx);
    check("err_code", {15'h0000, comm_err}, 16'h0001);
    check("n_cmd", 16'(n_cmd), 16'h0007);
    host.xfer(16, 16'h8710, rx);
    check("err_clr", {15'h0000, comm_err}, 16'h0000);
    host.xfer(16, 16'h8700, rx);
    // The clear answer still reports the error that it clears
    check("clr_resp", rx, resp(3'h0, {1'b1, 11'h2A1}));
    // Twelve clocks: not a multiple of eight, write must be dropped
    host.xfer(12, 16'hB777, rx);
    check("err_m8", {15'h0000, comm_err}, 16'h0001);
    check("n_wr_m8", 16'(n_wr), 16'h0001);
    host.xfer(16, 16'h8710, rx);
    // Chain frame: eight zero bits ahead of a no-operation
    host.xfer(24, 16'h8700, rx);
    check("chain_rx", rx, resp(3'h0, {1'b1, 11'h2A1}));
    // No-operation before switching to split bytes
    host.xfer(16, 16'h8700, rx);
    check("chain_nop", rx, 16'h0000);
    // New level before the frame, so the snapshot must follow it
    @(negedge clk);
    short_diag = 12'h5A6;
    host.xfer(16, 16'hC1C0, rx);
    check("split_lo", {8'h00, rx[7:0]}, 16'h0005);
    check("split_cb", {8'h00, last_cb}, 16'h00C0);
    host.xfer(16, 16'h8700, rx);
    check("split_hi", rx, 16'hA600);
    // Second reset in mid-run
    @(negedge clk);
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    host.xfer(16, 16'h8700, rx);
    check("rst2", rx, resp(3'h0, {1'b0, 11'h2A1}));
    close_out();
  end
endmodule
